// File: logic/ucrm_pkg.sv
package ucrm_pkg;
  // register offsets
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IEN = 3'h1;
  localparam logic [2:0] ADDR_IID = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LST = 3'h5;
  localparam logic [2:0] ADDR_MST = 3'h6;
  localparam logic [2:0] ADDR_SCR = 3'h7;
  // field positions
  localparam int LCR_DIV_SEL = 7;
  localparam int FCR_ENABLE = 0;
  localparam int FCR_RX_CLR = 1;
  localparam int FCR_TX_CLR = 2;
  localparam int MCR_LOOP = 4;
  // reset values
  localparam logic [7:0] IID_RESET = 8'h01;
  localparam logic [7:0] LST_RESET = 8'h60;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  // interrupt ids
  localparam logic [2:0] IID_LINE = 3'h3;
  localparam logic [2:0] IID_RXAV = 3'h2;
  localparam logic [2:0] IID_TIMEOUT = 3'h6;
  localparam logic [2:0] IID_TXEMP = 3'h1;
  localparam logic [2:0] IID_MODEM = 3'h0;
  localparam int OVERSAMPLE = 16;
endpackage : ucrm_pkg

// File: logic/ucrm_baud.sv
`timescale 1ns/1ps
// divides clk_in by the 16-bit divisor, one-cycle tick per period
module ucrm_baud
  import ucrm_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] divisor_in,
  output logic tick_out
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic tick;
  } ucrm_baud_t;
  ucrm_baud_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt + WIDTH'(1) >= divisor_in)
    begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + WIDTH'(1);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick_out = s_q.tick;
endmodule : ucrm_baud

// File: logic/ucrm_channel.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module ucrm_channel
  import ucrm_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic legacy_mode_in,
  input wire logic rxd_in,
  input wire logic cts_n_in,
  input wire logic dsr_n_in,
  input wire logic ri_n_in,
  input wire logic dcd_n_in,
  output logic txd_out,
  output logic dtr_n_out,
  output logic rts_n_out,
  output logic irq_out
);
  import ucrm_pkg::*;

  typedef struct packed {
    logic [7:0] ien;
    logic [7:0] line_control;
    logic [4:0] modem_control;
    logic [7:0] scratch_byte;
    logic [15:0] div;
    logic fifo_en;
    logic [1:0] trig;
    logic [7:0] rdata;
    logic [7:0] rx_buf;
    logic dready;
    logic overrun;
    logic perr;
    logic ferr;
    logic brk;
    logic [7:0] transmit_holding;
    logic thr_full;
    logic holding_empty_irq;
    logic [3:0] mdelta;
    logic [3:0] mlev_prev;
    logic [10:0] tx_sh;
    logic [3:0] tx_bits;
    logic [3:0] tx_sub;
    logic tx_busy;
    logic rx_busy;
    logic [3:0] rx_sub;
    logic [3:0] rx_bits;
    logic [9:0] rx_sh;
    logic [1:0] rx_sync;
    logic [7:0] mod_sync1;
    logic [3:0] mod_sync2;
  } ucrm_chan_t;

  ucrm_chan_t s_q, s_d;
  logic tick;
  logic divsel;
  logic [7:0] lst;
  logic [7:0] mst;
  logic [7:0] iid;
  logic [3:0] mlev;
  logic rxd_eff;
  logic [3:0] data_bits;
  logic [3:0] tx_total;
  logic par_bit;
  logic [2:0] id;
  logic pend;
  logic [3:0] mev;
  logic [7:0] rx_word;

  ucrm_baud #(.WIDTH(16)) u_baud (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .divisor_in(s_q.div),
    .tick_out(tick)
  );

  // ----------------------------------------------------------------
  // status composition
  // ----------------------------------------------------------------
  assign divsel = s_q.line_control[LCR_DIV_SEL];
  assign data_bits = 4'(5 + s_q.line_control[1:0]);
  assign mlev = s_q.modem_control[MCR_LOOP] ? {s_q.modem_control[3], s_q.modem_control[2], s_q.modem_control[0], s_q.modem_control[1]}
                                  : ~{s_q.mod_sync2[0], s_q.mod_sync2[1], s_q.mod_sync2[2], s_q.mod_sync2[3]};
  assign rxd_eff = s_q.modem_control[MCR_LOOP] ? 1'b1 : s_q.rx_sync[1];
  // modem events of this cycle, kept apart so that they win over a read clear
  assign mev = {mlev[3] ^ s_q.mlev_prev[3], s_q.mlev_prev[2] & !mlev[2], mlev[1] ^ s_q.mlev_prev[1],
                mlev[0] ^ s_q.mlev_prev[0]};
  // received character sits at the top of rx_sh, or just below the parity sample; the stop sample is not shifted in yet
  assign rx_word = 8'(s_q.rx_sh >> (4'ha - {3'h0, s_q.line_control[3]} - data_bits)) & (8'hff >> (8 - data_bits));

  always_comb
  begin
    lst = 8'h00;
    lst[0] = s_q.dready;
    lst[1] = s_q.overrun;
    lst[2] = s_q.perr;
    lst[3] = s_q.ferr;
    lst[4] = s_q.brk;
    lst[5] = !s_q.thr_full;
    // transmitter idle: legacy mode looks only at the shift register
    lst[6] = legacy_mode_in ? !s_q.tx_busy : (!s_q.tx_busy && !s_q.thr_full);
    lst[7] = s_q.fifo_en && (s_q.perr || s_q.ferr || s_q.brk);
  end

  assign mst = {mlev, s_q.mdelta};

  always_comb
  begin
    pend = 1'b1;
    id = IID_MODEM;
    if (s_q.ien[2] && (s_q.overrun || s_q.perr || s_q.ferr || s_q.brk))
      id = IID_LINE;
    else if (s_q.ien[0] && s_q.dready)
      id = IID_RXAV;
    else if (s_q.ien[1] && s_q.holding_empty_irq)
      id = IID_TXEMP;
    else if (s_q.ien[3] && (s_q.mdelta != 4'h0))
      id = IID_MODEM;
    else
      pend = 1'b0;
    iid = {{2{s_q.fifo_en}}, 2'b00, s_q.fifo_en & id[2], id[1:0], !pend};
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rx_sync = {s_q.rx_sync[0], rxd_in};
    s_d.mod_sync1 = {4'h0, cts_n_in, dsr_n_in, ri_n_in, dcd_n_in};
    s_d.mod_sync2 = s_q.mod_sync1[3:0];
    s_d.mlev_prev = mlev;
    s_d.mdelta = s_q.mdelta | mev;
    s_d.rdata = 8'h00;

    // read side effects and data; clears happen before new events below
    if (rd_in)
    begin
      unique case (addr_in)
        ADDR_DATA:
        begin
          s_d.rdata = divsel ? s_q.div[7:0] : s_q.rx_buf;
          if (!divsel)
            s_d.dready = 1'b0;
        end
        ADDR_IEN: s_d.rdata = divsel ? s_q.div[15:8] : {4'h0, s_q.ien[3:0]};
        ADDR_IID:
        begin
          s_d.rdata = iid;
          if (id == IID_TXEMP && pend)
            s_d.holding_empty_irq = 1'b0;
        end
        ADDR_LCR: s_d.rdata = s_q.line_control;
        ADDR_MCR: s_d.rdata = {3'h0, s_q.modem_control};
        ADDR_LST:
        begin
          s_d.rdata = lst;
          s_d.overrun = 1'b0;
          s_d.perr = 1'b0;
          s_d.ferr = 1'b0;
          s_d.brk = 1'b0;
        end
        ADDR_MST:
        begin
          s_d.rdata = mst;
          s_d.mdelta = mev;
        end
        ADDR_SCR: s_d.rdata = legacy_mode_in ? 8'h00 : s_q.scratch_byte;
      endcase
    end

    if (wr_in)
    begin
      unique case (addr_in)
        ADDR_DATA:
        begin
          if (divsel)
            s_d.div[7:0] = wdata_in;
          else
          begin
            s_d.transmit_holding = wdata_in;
            s_d.thr_full = 1'b1;
            s_d.holding_empty_irq = 1'b0;
          end
        end
        ADDR_IEN:
        begin
          if (divsel)
            s_d.div[15:8] = wdata_in;
          else
            s_d.ien = {4'h0, wdata_in[3:0]};
        end
        ADDR_IID:
        begin
          // dma select bit 3 is deliberately not stored
          s_d.fifo_en = wdata_in[FCR_ENABLE];
          s_d.trig = wdata_in[7:6];
          if (wdata_in[FCR_RX_CLR])
            s_d.dready = 1'b0;
          if (wdata_in[FCR_TX_CLR])
            s_d.thr_full = 1'b0;
        end
        ADDR_LCR: s_d.line_control = wdata_in;
        ADDR_MCR: s_d.modem_control = wdata_in[4:0];
        ADDR_SCR:
        begin
          if (!legacy_mode_in)
            s_d.scratch_byte = wdata_in;
        end
        default: ;
      endcase
    end

    // transmitter: start, data lsb first, parity, stop
    tx_total = 4'(1 + data_bits + {3'h0, s_q.line_control[3]} + 4'(1 + s_q.line_control[2]));
    par_bit = s_q.line_control[5] ? !s_q.line_control[4] : (^(s_q.transmit_holding & (8'hff >> (8 - data_bits))) ^ !s_q.line_control[4]);
    if (tick)
    begin
      if (!s_q.tx_busy && s_q.thr_full)
      begin
        s_d.tx_busy = 1'b1;
        s_d.tx_sub = 4'h0;
        s_d.tx_bits = 4'h0;
        // bits above the word length go out as stop level
        s_d.tx_sh = {1'b1, 1'b1, s_q.transmit_holding | ~(8'hff >> (8 - data_bits)), 1'b0};
        if (s_q.line_control[3])
          s_d.tx_sh[data_bits + 1] = par_bit;
        s_d.thr_full = 1'b0;
        s_d.holding_empty_irq = 1'b1;
      end
      else if (s_q.tx_busy)
      begin
        s_d.tx_sub = s_q.tx_sub + 4'h1;
        if (s_q.tx_sub == 4'(OVERSAMPLE - 1))
        begin
          s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
          s_d.tx_bits = s_q.tx_bits + 4'h1;
          if (s_q.tx_bits + 4'h1 == tx_total)
            s_d.tx_busy = 1'b0;
        end
      end
    end

    // receiver: centre sampled, lsb first
    if (tick)
    begin
      if (!s_q.rx_busy)
      begin
        if (!rxd_eff)
        begin
          s_d.rx_busy = 1'b1;
          s_d.rx_sub = 4'h0;
          s_d.rx_bits = 4'h0;
        end
      end
      else
      begin
        s_d.rx_sub = s_q.rx_sub + 4'h1;
        if (s_q.rx_sub == 4'(OVERSAMPLE / 2 - 1))
        begin
          s_d.rx_sh = {rxd_eff, s_q.rx_sh[9:1]};
          s_d.rx_bits = s_q.rx_bits + 4'h1;
          if (s_q.rx_bits == 4'h0 && rxd_eff)
            s_d.rx_busy = 1'b0;
          else if (s_q.rx_bits == data_bits + {3'h0, s_q.line_control[3]} + 4'h1)
          begin
            s_d.rx_busy = 1'b0;
            s_d.rx_buf = rx_word;
            s_d.dready = 1'b1;
            s_d.overrun = s_q.overrun | s_q.dready;
            s_d.ferr = s_q.ferr | !rxd_eff;
            s_d.brk = s_q.brk | (!rxd_eff && rx_word == 8'h00);
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s_q <= '0;
      s_q.div <= DIV_RESET;
      s_q.tx_sh <= '1;
      s_q.rx_sync <= 2'b11;
      s_q.mod_sync1 <= 8'hff;
      s_q.mod_sync2 <= 4'hf;
    end
    else
      s_q <= s_d;
  end

  assign rdata_out = s_q.rdata;
  assign txd_out = s_q.modem_control[MCR_LOOP] ? 1'b1 : (s_q.line_control[6] ? 1'b0 : s_q.tx_sh[0]);
  assign dtr_n_out = !s_q.modem_control[0] | s_q.modem_control[MCR_LOOP];
  assign rts_n_out = !s_q.modem_control[1] | s_q.modem_control[MCR_LOOP];
  assign irq_out = pend;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ien_upper_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rd_in && addr_in == ADDR_IEN && !divsel |=> rdata_out[7:4] == 4'h0)
    else $error("ien upper bits not zero");
  a_iid_nofifo: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rd_in && addr_in == ADDR_IID && !s_q.fifo_en |=> rdata_out[7:6] == 2'b00 && rdata_out[3] == 1'b0)
    else $error("fifo bits set without fifo");
  a_div_low_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rd_in && addr_in == ADDR_DATA && divsel |=> rdata_out == $past(s_q.div[7:0]))
    else $error("divisor low read wrong");
  a_thr_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
    wr_in && addr_in == ADDR_DATA && !divsel |=> s_q.transmit_holding == $past(wdata_in))
    else $error("holding register not loaded");
  a_scr_legacy: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rd_in && addr_in == ADDR_SCR && legacy_mode_in |=> rdata_out == 8'h00)
    else $error("scratch visible in legacy mode");
  a_mcr_upper: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rd_in && addr_in == ADDR_MCR |=> rdata_out[7:5] == 3'h0)
    else $error("modem control upper bits set");
  a_rx_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    rd_in && addr_in == ADDR_DATA && !divsel |=> rdata_out == $past(s_q.rx_buf) && !s_q.dready)
    else $error("receive read wrong");
  a_legacy_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
    legacy_mode_in && !s_q.tx_busy |-> lst[6])
    else $error("idle flag wrong in legacy mode");
endmodule : ucrm_channel

// File: test/ucrm_far_end.sv
`timescale 1ns/1ps
// ----------------------------------------
// far-end serial device, 16 clocks per bit
// ----------------------------------------
module ucrm_far_end
(
  input wire logic clk_in,
  input wire logic txd_in,
  output logic rxd_out,
  output logic cts_n_out,
  output logic [7:0] got_out,
  output logic [7:0] got_cnt_out
);
  initial
  begin
    rxd_out = 1'b1;
    cts_n_out = 1'b1;
    got_out = 8'h00;
    got_cnt_out = 8'h00;
  end
  // samples each bit in mid period after the start edge
  always
  begin
    @(negedge txd_in);
    repeat (8) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      repeat (16) @(posedge clk_in);
      got_out[i] = txd_in;
    end
    repeat (16) @(posedge clk_in);
    got_cnt_out <= got_cnt_out + 8'h01;
  end
  task automatic send_byte(input logic [7:0] b);
    rxd_out <= 1'b0;
    repeat (16) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      rxd_out <= b[i];
      repeat (16) @(posedge clk_in);
    end
    rxd_out <= 1'b1;
    repeat (16) @(posedge clk_in);
  endtask : send_byte
  task automatic set_cts(input logic v);
    cts_n_out <= v;
  endtask : set_cts
endmodule : ucrm_far_end

// File: test/uart_channel_register_map_tb.sv
`timescale 1ns/1ps
module uart_channel_register_map_tb;
  import ucrm_pkg::*;
  logic clk_in, nrst_in, wr_in, rd_in, legacy_mode_in, cts_n, txd, dtr_n, rts_n, irq, rxd;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, rdata, got, got_cnt, base;
  int error_cnt = 0;
  int checks_done = 0;
  ucrm_channel ucrm_channel_inst (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .legacy_mode_in(legacy_mode_in), .rxd_in(rxd),
    .cts_n_in(cts_n), .dsr_n_in(1'b1), .ri_n_in(1'b1), .dcd_n_in(1'b1), .txd_out(txd), .dtr_n_out(dtr_n),
    .rts_n_out(rts_n), .irq_out(irq));
  ucrm_far_end ucrm_far_end_inst (.clk_in(clk_in), .txd_in(txd), .rxd_out(rxd), .cts_n_out(cts_n),
    .got_out(got), .got_cnt_out(got_cnt));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask : rchk
  task automatic wait_cnt(input logic [7:0] n);
    int k;
    for (k = 0; k < 1000 && got_cnt !== n; k++)
      @(posedge clk_in);
    if (got_cnt !== n)
    begin
      error_cnt++;
      report_and_stop();
    end
  endtask : wait_cnt
  initial
  begin
    clk_in = 1'b0;
    forever
      #25 clk_in = ~clk_in;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    nrst_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 3'h0;
    wdata_in = 8'h00;
    legacy_mode_in = 1'b0;
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    rchk("ien", ADDR_IEN, 8'h00);
    rchk("iid", ADDR_IID, IID_RESET);
    rchk("lcr", ADDR_LCR, 8'h00);
    rchk("mcr", ADDR_MCR, 8'h00);
    rchk("lst", ADDR_LST, LST_RESET);
    rchk("mst", ADDR_MST, 8'h00);
    chk("dtr", {7'h0, dtr_n}, 8'h01);
    wr(ADDR_IEN, 8'hff);
    rchk("ien", ADDR_IEN, 8'h0f);
    wr(ADDR_MCR, 8'hff);
    rchk("mcr", ADDR_MCR, 8'h1f);
    chk("loop dtr", {7'h0, dtr_n}, 8'h01);
    wr(ADDR_MCR, 8'h03);
    chk("dtr rts", {6'h0, dtr_n, rts_n}, 8'h00);
    wr(ADDR_MCR, 8'h00);
    rchk("mst loop", ADDR_MST, 8'h0f);
    wr(ADDR_LST, 8'hff);
    rchk("lst ro", ADDR_LST, LST_RESET);
    wr(ADDR_LCR, 8'h80);
    wr(ADDR_DATA, 8'h34);
    wr(ADDR_IEN, 8'h12);
    rchk("div lo", ADDR_DATA, 8'h34);
    rchk("div hi", ADDR_IEN, 8'h12);
    wr(ADDR_DATA, 8'h01);
    wr(ADDR_IEN, 8'h00);
    wr(ADDR_LCR, 8'h7f);
    rchk("lcr", ADDR_LCR, 8'h7f);
    chk("break", {7'h0, txd}, 8'h00);
    wr(ADDR_LCR, 8'h03);
    rchk("ien back", ADDR_IEN, 8'h0f);
    repeat (200) @(posedge clk_in);
    wr(ADDR_SCR, 8'ha5);
    rchk("scr", ADDR_SCR, 8'ha5);
    legacy_mode_in <= 1'b1;
    wr(ADDR_SCR, 8'h5a);
    rchk("scr hidden", ADDR_SCR, 8'h00);
    legacy_mode_in <= 1'b0;
    rchk("scr legacy", ADDR_SCR, 8'ha5);
    wr(ADDR_IEN, 8'h00);
    wr(ADDR_IID, 8'h09);
    rchk("iid fifo", ADDR_IID, 8'hc1);
    wr(ADDR_IID, 8'h00);
    rchk("iid nofifo", ADDR_IID, 8'h01);
    // ----------------------------------------
    // transmit and interrupt
    // ----------------------------------------
    wr(ADDR_IEN, 8'h02);
    base = got_cnt;
    wr(ADDR_DATA, 8'h96);
    wait_cnt(base + 8'h01);
    chk("tx byte", got, 8'h96);
    repeat (20) @(posedge clk_in);
    rchk("lst idle", ADDR_LST, 8'h60);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(ADDR_IEN, 8'h00);
    chk("irq masked", {7'h0, irq}, 8'h00);
    wr(ADDR_IEN, 8'h02);
    chk("irq unmasked", {7'h0, irq}, 8'h01);
    rchk("iid tx", ADDR_IID, 8'h02);
    chk("irq cleared", {7'h0, irq}, 8'h00);
    // ----------------------------------------
    // receive and modem status
    // ----------------------------------------
    ucrm_far_end_inst.send_byte(8'h3c);
    repeat (4) @(posedge clk_in);
    rchk("lst ready", ADDR_LST, 8'h61);
    wr(ADDR_IEN, 8'h01);
    rchk("iid rx", ADDR_IID, 8'h04);
    rchk("rx byte", ADDR_DATA, 8'h3c);
    rchk("lst empty", ADDR_LST, 8'h60);
    wr(ADDR_IEN, 8'h08);
    ucrm_far_end_inst.set_cts(1'b0);
    repeat (6) @(posedge clk_in);
    #1;
    chk("irq modem", {7'h0, irq}, 8'h01);
    rchk("iid modem", ADDR_IID, 8'h00);
    rchk("mst delta", ADDR_MST, 8'h11);
    chk("irq modem off", {7'h0, irq}, 8'h00);
    rchk("mst level", ADDR_MST, 8'h10);
    report_and_stop();
  end
endmodule : uart_channel_register_map_tb
